// ==== design/timer16_compare_out.sv ====
// one compare output channel: internal output state and its actions
`timescale 1ns/100ps
module timer16_compare_out
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // configuration
  input wire logic non_pwm,
  input wire logic [1:0] output_mode,
  // events
  input wire logic match,
  input wire logic force_strobe,
  // internal output state
  output logic state
);
  logic hit;
  logic [1:0] action;
  logic next_state;

  // action applied to the current state
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      ACT_TOGGLE: apply_action = ~cur;
      ACT_CLEAR: apply_action = 1'b0;
      ACT_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction

  // mode is read live so a new setting acts on the very next match
  assign hit = match || (force_strobe && non_pwm);
  assign action = non_pwm ? output_mode : ACT_NONE;
  assign next_state = hit ? apply_action(action, state) : state;

  // cleared at reset whatever the pin shows
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= 1'b0;
    end else if (ce) begin
      state <= next_state;
    end
  end
endmodule

// ==== design/timer16_compare_timer.sv ====
// 16-bit timer with compare outputs, normal and clear-on-match modes
//
// Functional notes
// - reset clears compare output states to zero
// - nonzero mode routes output state to pin
// - output mode never affects input capture
// - mode zero leaves state unchanged on match
// - new mode acts from next match onward
// - force strobe applies action immediately, non-pwm
// - only waveform mode selects counting sequence
// - mode picks set, clear or toggle
// - normal mode counts up, wraps max to zero
// - overflow flag set when counter wraps from max, not on a top clear below max
// - overflow acknowledge clears the overflow flag
// - counter writable any time in normal mode
// - clear at top: compare a or capture
// - reaching top sets the matching top flag
// - top below count runs through wrap first
// - toggle mode toggles channel a per match
// - toggle rate clock over 2N(1+compare)
// - overflow flag set passing max to zero
// - output state settable before pin enabled
// - compare flag set on the matching tick
// - force sets no flag, leaves counter alone
// - counter write blocks matches for one tick
`timescale 1ns/100ps
module timer16_compare_timer
  import timer16_pkg::*;
(
  // clock, reset and freeze
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // capture pin and overflow interrupt acknowledge
  input wire logic capture_pin,
  input wire logic overflow_ack,
  // compare pins, bit 0 channel a, bit 1 channel b
  output logic [1:0] compare_pin_out,
  output logic [1:0] compare_pin_oe,
  // event flags
  output logic overflow_flag,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic capture_flag
);
  // software-visible configuration and values
  logic [3:0] waveform_mode_select;
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  logic [2:0] clock_select;
  logic [15:0] counter_value;
  logic [15:0] compare_a_value;
  logic [15:0] compare_b_value;
  logic [15:0] capture_top_value;
  logic [1:0] port_value;
  logic [1:0] compare_pin_direction;
  logic block_match;
  bus_state_e bus_state;
  // capture pin synchroniser and settled level
  logic [2:0] capture_sync;
  logic capture_level;
  // internal output states
  logic chan_a_output_state, chan_b_output_state, tick;

  // byte lane mask from avalon byte enables
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // merge enabled write lanes into an old register image
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] be);
    merge_bytes = (data & lane_mask(be)) | (old & ~lane_mask(be));
  endfunction

  // bus decode: a write lands at the edge where waitrequest is seen low
  logic write_take;
  logic [31:0] write_ones;
  logic wr_control, wr_force, wr_counter, wr_compare_a;
  logic wr_compare_b, wr_capture, wr_flags, wr_pin;
  assign write_take = avs_write && (bus_state == BUS_ANSWER);
  assign write_ones = avs_writedata & lane_mask(avs_byteenable);
  assign wr_control = write_take && (avs_address == REG_CONTROL);
  assign wr_force = write_take && (avs_address == REG_FORCE);
  assign wr_counter = write_take && (avs_address == REG_COUNTER);
  assign wr_compare_a = write_take && (avs_address == REG_COMPARE_A);
  assign wr_compare_b = write_take && (avs_address == REG_COMPARE_B);
  assign wr_capture = write_take && (avs_address == REG_CAPTURE);
  assign wr_flags = write_take && (avs_address == REG_FLAGS);
  assign wr_pin = write_take && (avs_address == REG_PIN);

  // register images as software sees them; unused bits read zero
  logic [31:0] control_word, flags_word, pin_word, read_word;
  assign control_word = {21'h000000, clock_select, chan_b_output_mode, chan_a_output_mode,
                         waveform_mode_select};
  assign flags_word = {28'h0000000, capture_flag, compare_b_flag, compare_a_flag,
                       overflow_flag};
  assign pin_word = {26'h0000000, chan_b_output_state, chan_a_output_state,
                     compare_pin_direction, port_value};
  assign read_word =
    (avs_address == REG_CONTROL) ? control_word :
    (avs_address == REG_COUNTER) ? {16'h0000, counter_value} :
    (avs_address == REG_COMPARE_A) ? {16'h0000, compare_a_value} :
    (avs_address == REG_COMPARE_B) ? {16'h0000, compare_b_value} :
    (avs_address == REG_CAPTURE) ? {16'h0000, capture_top_value} :
    (avs_address == REG_FLAGS) ? flags_word :
    (avs_address == REG_PIN) ? pin_word : 32'h00000000;

  // merged write images
  logic [31:0] next_control, next_pin_word, next_counter_word;
  assign next_control = merge_bytes(control_word, avs_writedata, avs_byteenable);
  assign next_pin_word = merge_bytes(pin_word, avs_writedata, avs_byteenable);
  assign next_counter_word = merge_bytes({16'h0000, counter_value}, avs_writedata,
                                         avs_byteenable);

  // fixed one wait state; unmapped reads return zero, unmapped writes vanish
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_state <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      case (bus_state)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata <= read_word;
          end
        end
        BUS_ANSWER: begin
          bus_state <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waveform_mode_select <= WAVE_RESET;
      chan_a_output_mode <= MODE_RESET;
      chan_b_output_mode <= MODE_RESET;
      clock_select <= CLKSEL_RESET;
      compare_a_value <= VALUE_RESET;
      compare_b_value <= VALUE_RESET;
      port_value <= PIN_RESET;
      compare_pin_direction <= PIN_RESET;
    end else if (ce) begin
      if (wr_control) begin
        waveform_mode_select <= next_control[CTL_WAVE_LSB +: 4];
        chan_a_output_mode <= next_control[CTL_MODE_A_LSB +: 2];
        chan_b_output_mode <= next_control[CTL_MODE_B_LSB +: 2];
        clock_select <= next_control[CTL_CLKSEL_LSB +: 3];
      end
      // no double buffer in these modes: a top write acts at once
      if (wr_compare_a) begin
        compare_a_value <= 16'(merge_bytes({16'h0000, compare_a_value}, avs_writedata,
                                           avs_byteenable));
      end
      if (wr_compare_b) begin
        compare_b_value <= 16'(merge_bytes({16'h0000, compare_b_value}, avs_writedata,
                                           avs_byteenable));
      end
      if (wr_pin) begin
        port_value <= next_pin_word[PIN_PORT_LSB +: 2];
        compare_pin_direction <= next_pin_word[PIN_DIR_LSB +: 2];
      end
    end
  end

  // timer clock from the prescaler
  timer16_prescaler u_prescaler (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .clock_select(clock_select),
    .tick(tick)
  );

  // counting sequence depends on the waveform mode alone
  logic clear_mode, non_pwm, at_top, wraps;
  logic [15:0] top_value, next_count;
  assign clear_mode = (waveform_mode_select == WAVE_MATCH_A) ||
                      (waveform_mode_select == WAVE_MATCH_CAPTURE);
  assign non_pwm = (waveform_mode_select == WAVE_NORMAL) || clear_mode;
  assign top_value = (waveform_mode_select == WAVE_MATCH_CAPTURE) ? capture_top_value :
                     compare_a_value;
  // equality only: a top below the count is missed until after the wrap
  assign at_top = clear_mode && !block_match && (counter_value == top_value);
  assign wraps = tick && (counter_value == COUNT_MAX);
  assign next_count = at_top ? COUNT_BOTTOM : counter_value + 16'h0001;

  // matches, all suppressed in the tick after a counter write
  logic match_a, match_b, match_capture;
  assign match_a = tick && !block_match && (counter_value == compare_a_value);
  assign match_b = tick && !block_match && (counter_value == compare_b_value);
  assign match_capture = tick && !block_match &&
                         (waveform_mode_select == WAVE_MATCH_CAPTURE) &&
                         (counter_value == capture_top_value);

  // counter: a software write wins over the tick, in any mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      counter_value <= VALUE_RESET;
      block_match <= 1'b0;
    end else if (ce) begin
      if (wr_counter) begin
        counter_value <= next_counter_word[15:0];
      end else if (tick) begin
        counter_value <= next_count;
      end
      // held while stopped, so the block waits for the next real tick
      if (wr_counter) begin
        block_match <= 1'b1;
      end else if (tick) begin
        block_match <= 1'b0;
      end
    end
  end

  // capture pin: the change counts once the second and third stages agree
  logic capture_settled, capture_rise, capture_enabled;
  assign capture_settled = (capture_sync[1] == capture_sync[2]);
  assign capture_rise = capture_settled && capture_sync[2] && !capture_level;
  // capture depends on waveform mode only, never on the output modes
  assign capture_enabled = (waveform_mode_select != WAVE_MATCH_CAPTURE);

  // synchroniser and capture register; a hardware capture beats a write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capture_sync <= 3'h0;
      capture_level <= 1'b0;
      capture_top_value <= VALUE_RESET;
    end else if (ce) begin
      capture_sync <= {capture_sync[1:0], capture_pin};
      if (capture_settled) begin
        capture_level <= capture_sync[2];
      end
      if (capture_rise && capture_enabled) begin
        capture_top_value <= counter_value;
      end else if (wr_capture) begin
        capture_top_value <= 16'(merge_bytes({16'h0000, capture_top_value}, avs_writedata,
                                             avs_byteenable));
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  logic next_overflow, next_compare_a, next_compare_b, next_capture;
  assign next_overflow = wraps || (overflow_flag && !(overflow_ack ||
                         (wr_flags && write_ones[FLG_OVERFLOW])));
  assign next_compare_a = match_a || (compare_a_flag && !(wr_flags && write_ones[FLG_CMP_A]));
  assign next_compare_b = match_b || (compare_b_flag && !(wr_flags && write_ones[FLG_CMP_B]));
  assign next_capture = match_capture || (capture_rise && capture_enabled) ||
                        (capture_flag && !(wr_flags && write_ones[FLG_CAPTURE]));

  // flag registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overflow_flag <= 1'b0;
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
      capture_flag <= 1'b0;
    end else if (ce) begin
      overflow_flag <= next_overflow;
      compare_a_flag <= next_compare_a;
      compare_b_flag <= next_compare_b;
      capture_flag <= next_capture;
    end
  end

  // force strobes reach only the output state, never flags or counter
  logic force_a, force_b;
  assign force_a = wr_force && write_ones[FRC_A_BIT];
  assign force_b = wr_force && write_ones[FRC_B_BIT];

  // output state per channel
  timer16_compare_out u_chan_a (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .non_pwm(non_pwm),
    .output_mode(chan_a_output_mode),
    .match(match_a),
    .force_strobe(force_a),
    .state(chan_a_output_state)
  );
  timer16_compare_out u_chan_b (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .non_pwm(non_pwm),
    .output_mode(chan_b_output_mode),
    .match(match_b),
    .force_strobe(force_b),
    .state(chan_b_output_state)
  );

  // pin override: any nonzero mode takes the pin from the output state, mode zero from the port bit
  logic [1:0] next_pin_out;
  assign next_pin_out[0] = (chan_a_output_mode != ACT_NONE) ? chan_a_output_state :
                           port_value[0];
  assign next_pin_out[1] = (chan_b_output_mode != ACT_NONE) ? chan_b_output_state :
                           port_value[1];

  // direction stays with software, so state can be preset undriven
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      compare_pin_out <= 2'h0;
      compare_pin_oe <= 2'h0;
    end else if (ce) begin
      compare_pin_out <= next_pin_out;
      compare_pin_oe <= compare_pin_direction;
    end
  end

  // checks next to the logic
  a_overflow_sets: assert property (@(posedge clk) disable iff (reset)
    ce && wraps |=> overflow_flag)
    else $error("overflow flag not set on wrap");
  a_normal_wraps: assert property (@(posedge clk) disable iff (reset)
    ce && wraps && !wr_counter && !clear_mode |=> counter_value == 16'h0000)
    else $error("counter did not wrap to zero");
  a_top_clears: assert property (@(posedge clk) disable iff (reset)
    ce && tick && at_top && !wr_counter && waveform_mode_select == WAVE_MATCH_A
    |=> counter_value == 16'h0000 && compare_a_flag)
    else $error("top match did not clear counter and flag");
  a_write_blocks: assert property (@(posedge clk) disable iff (reset)
    ce && tick && block_match |=> !$rose(compare_a_flag) && !$rose(compare_b_flag))
    else $error("match not blocked after counter write");
  a_write_arms: assert property (@(posedge clk) disable iff (reset)
    ce && wr_counter |=> block_match)
    else $error("counter write did not arm the match block");
  a_toggle_match: assert property (@(posedge clk) disable iff (reset)
    ce && match_a && clear_mode && chan_a_output_mode == ACT_TOGGLE
    |=> chan_a_output_state != $past(chan_a_output_state))
    else $error("channel a did not toggle");
  a_mode_zero_hold: assert property (@(posedge clk) disable iff (reset)
    ce && chan_b_output_mode == ACT_NONE |=> $stable(chan_b_output_state))
    else $error("output state moved with mode zero");
  a_force_no_flag: assert property (@(posedge clk) disable iff (reset)
    ce && force_a && !match_a && !compare_a_flag |=> !compare_a_flag)
    else $error("force set the compare flag");
  a_pin_override: assert property (@(posedge clk) disable iff (reset)
    ce && chan_a_output_mode != ACT_NONE |=> compare_pin_out[0] == $past(chan_a_output_state))
    else $error("pin not taken from output state");
  a_bus_answer: assert property (@(posedge clk) disable iff (reset)
    ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one wait state");
  a_bus_release: assert property (@(posedge clk) disable iff (reset)
    ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule

// ==== design/timer16_pkg.sv ====
// constants, register map and encodings for the 16-bit compare timer
package timer16_pkg;
  // counter range
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  // register byte addresses, one aligned word each
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_FORCE = 5'h04;
  localparam logic [4:0] REG_COUNTER = 5'h08;
  localparam logic [4:0] REG_COMPARE_A = 5'h0c;
  localparam logic [4:0] REG_COMPARE_B = 5'h10;
  localparam logic [4:0] REG_CAPTURE = 5'h14;
  localparam logic [4:0] REG_FLAGS = 5'h18;
  localparam logic [4:0] REG_PIN = 5'h1c;
  // control register fields
  localparam int CTL_WAVE_LSB = 0;
  localparam int CTL_MODE_A_LSB = 4;
  localparam int CTL_MODE_B_LSB = 6;
  localparam int CTL_CLKSEL_LSB = 8;
  // force strobe bits
  localparam int FRC_A_BIT = 0;
  localparam int FRC_B_BIT = 1;
  // flag bits, write one to clear
  localparam int FLG_OVERFLOW = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;
  localparam int FLG_CAPTURE = 3;
  // pin register fields
  localparam int PIN_PORT_LSB = 0;
  localparam int PIN_DIR_LSB = 2;
  localparam int PIN_STATE_LSB = 4;
  // reset values
  localparam logic [3:0] WAVE_RESET = 4'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [1:0] PIN_RESET = 2'h0;
  // waveform modes handled here
  localparam logic [3:0] WAVE_NORMAL = 4'h0;
  localparam logic [3:0] WAVE_MATCH_A = 4'h4;
  localparam logic [3:0] WAVE_MATCH_CAPTURE = 4'hc;
  // output actions in non-pwm modes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // prescaler clock selection and divisors
  localparam logic [2:0] CLKSEL_STOP = 3'h0;
  localparam logic [2:0] CLKSEL_DIV1 = 3'h1;
  localparam logic [2:0] CLKSEL_DIV8 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h3;
  localparam logic [2:0] CLKSEL_DIV256 = 3'h4;
  localparam logic [2:0] CLKSEL_DIV1024 = 3'h5;
  localparam int DIV_8 = 8;
  localparam int DIV_64 = 64;
  localparam int DIV_256 = 256;
  localparam int DIV_1024 = 1024;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_e;
endpackage

// ==== design/timer16_prescaler.sv ====
// prescaler producing the timer clock enable from the system clock
`timescale 1ns/100ps
module timer16_prescaler
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // divisor selection
  input wire logic [2:0] clock_select,
  // one-cycle timer clock enable
  output logic tick
);
  logic [9:0] div_count;
  logic [9:0] div_limit;
  logic running;
  logic at_limit;

  // terminal count for each division factor
  function automatic logic [9:0] limit_of(input logic [2:0] sel);
    case (sel)
      CLKSEL_DIV8: limit_of = 10'(DIV_8 - 1);
      CLKSEL_DIV64: limit_of = 10'(DIV_64 - 1);
      CLKSEL_DIV256: limit_of = 10'(DIV_256 - 1);
      CLKSEL_DIV1024: limit_of = 10'(DIV_1024 - 1);
      default: limit_of = 10'h000;
    endcase
  endfunction

  // selection decode; a stopped timer holds the divider at zero
  assign div_limit = limit_of(clock_select);
  assign running = (clock_select != CLKSEL_STOP) && (clock_select <= CLKSEL_DIV1024);
  assign at_limit = (div_count >= div_limit);

  // divide by N = 1, 8, 64, 256 or 1024
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_count <= 10'h000;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= running && at_limit;
      div_count <= (!running || at_limit) ? 10'h000 : div_count + 10'h001;
    end
  end
endmodule

// ==== verif/pin_load.sv ====
// external load on the compare pins
`timescale 1ns/100ps
module pin_load (
  // pins from the timer
  input wire logic [1:0] drive,
  input wire logic [1:0] enable,
  // resolved pin levels
  output logic [1:0] level
);
  // released pin rises to the pull-up, never keeps the last value
  assign level = (drive & enable) | ~enable;
endmodule

// ==== verif/timer16_compare_output_normal_ctc_tb_top.sv ====
// bench for the compare timer: forced actions, pin routing, toggle, overflow
`timescale 1ns/100ps
module timer16_compare_output_normal_ctc_tb_top;
  import timer16_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic rd = 0;
  logic wr = 0;
  logic ack = 0;
  logic cap = 0;
  logic [4:0] adr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic [31:0] val;
  logic wait_req;
  logic [1:0] pout;
  logic [1:0] poe;
  logic [1:0] lvl;
  logic ovf, cfa, cfb, cfc;
  logic [1:0] acts [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
  logic exp_st [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int failures = 0;
  int comparisons = 0;
  int gap;
  timer16_compare_timer uut (.clk(clk), .reset(reset), .ce(1'b1), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .capture_pin(cap),
    .overflow_ack(ack), .compare_pin_out(pout), .compare_pin_oe(poe),
    .overflow_flag(ovf), .compare_a_flag(cfa), .compare_b_flag(cfb), .capture_flag(cfc));
  pin_load load (.drive(pout), .enable(poe), .level(lvl));
  initial forever #5 clk = ~clk;
  task stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle; held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    val = rdata;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  // edges until channel a pin changes
  task pin_gap;
    logic old;
    old = pout[0];
    gap = 0;
    while (pout[0] === old && gap < 200) begin
      @(posedge clk);
      gap++;
    end
  endtask
  function automatic logic [31:0] ctl(logic [3:0] w, logic [1:0] m, logic [2:0] c);
    return 32'(w) | (32'(m) << CTL_MODE_A_LSB) | (32'(c) << CTL_CLKSEL_LSB);
  endfunction
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    bus(0, REG_PIN, 0);
    check("state after reset", 0, val);
    // forced actions while stopped and the pin released
    for (int i = 0; i < 4; i++) begin
      bus(1, REG_CONTROL, ctl(WAVE_NORMAL, acts[i], CLKSEL_STOP));
      bus(1, REG_FORCE, 32'h1);
      bus(0, REG_PIN, 0);
      check("forced state", {26'h0, 1'b0, exp_st[i], 4'h0}, val);
    end
    check("flag after force", 0, {30'h0, cfa, ovf});
    bus(0, REG_COUNTER, 0);
    check("counter after force", 0, val);
    // port bit 0, direction out: mode none shows port, toggle shows state
    bus(1, REG_PIN, 32'h4);
    repeat (2) @(posedge clk);
    check("pin port value", 0, 32'(lvl[0]));
    check("pin b released", 1, 32'(lvl[1]));
    bus(1, REG_CONTROL, ctl(WAVE_NORMAL, ACT_TOGGLE, CLKSEL_STOP));
    repeat (2) @(posedge clk);
    check("pin state value", 1, 32'(lvl[0]));
    // clear on compare a at 3, divide by 1: toggle every 4 cycles
    bus(1, REG_COMPARE_A, 32'h3);
    bus(1, REG_CONTROL, ctl(WAVE_MATCH_A, ACT_TOGGLE, CLKSEL_DIV1));
    pin_gap;
    pin_gap;
    check("toggle half period", 4, gap);
    bus(0, REG_COUNTER, 0);
    check("count within top", 1, 32'(val <= 32'h3));
    check("compare a flag", 1, 32'(cfa));
    // normal mode wrap from the top of the range
    bus(1, REG_CONTROL, ctl(WAVE_NORMAL, ACT_NONE, CLKSEL_STOP));
    bus(1, REG_FLAGS, 32'hf);
    bus(1, REG_COUNTER, 32'hfffd);
    check("overflow clear", 0, 32'(ovf));
    bus(1, REG_CONTROL, ctl(WAVE_NORMAL, ACT_NONE, CLKSEL_DIV1));
    repeat (6) @(posedge clk);
    check("overflow set", 1, 32'(ovf));
    check("compare b flag", 1, 32'(cfb));
    bus(0, REG_COUNTER, 0);
    check("counter wrapped", 1, 32'(val < 32'h20));
    ack <= 1;
    @(posedge clk);
    ack <= 0;
    @(posedge clk);
    @(posedge clk);
    check("overflow acknowledged", 0, 32'(ovf));
    // clear on the capture register at 5, started from zero while stopped
    bus(1, REG_CONTROL, ctl(WAVE_NORMAL, ACT_NONE, CLKSEL_STOP));
    bus(1, REG_CAPTURE, 32'h5);
    bus(1, REG_COUNTER, 0);
    bus(1, REG_FLAGS, 32'hf);
    bus(1, REG_CONTROL, ctl(WAVE_MATCH_CAPTURE, ACT_NONE, CLKSEL_DIV1));
    repeat (20) @(posedge clk);
    check("capture flag at top", 1, 32'(cfc));
    bus(0, REG_COUNTER, 0);
    check("count within capture top", 1, 32'(val <= 32'h5));
    // capture pin edge in normal mode with an output mode set
    bus(1, REG_CONTROL, ctl(WAVE_NORMAL, ACT_TOGGLE, CLKSEL_DIV1));
    bus(1, REG_FLAGS, 32'h8);
    cap <= 1;
    repeat (8) @(posedge clk);
    check("capture flag on pin edge", 1, 32'(cfc));
    stop_test;
  end
endmodule
